// ==== design/lvs_pkg.sv ====
// Package for the legacy display status and control register bank
package lvs_pkg;
  // Port addresses
  localparam logic [15:0] PORT_MISC_WR = 16'h03c2;
  localparam logic [15:0] PORT_MISC_RD = 16'h03cc;
  localparam logic [15:0] PORT_SEQ_IDX = 16'h03c4;
  localparam logic [15:0] PORT_SEQ_DAT = 16'h03c5;
  localparam logic [15:0] PORT_FEAT_RD = 16'h03ca;
  localparam logic [15:0] PORT_STAT_MONO = 16'h03ba;
  localparam logic [15:0] PORT_STAT_COLR = 16'h03da;
  // Reset values
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] FEAT_RST = 8'h00;
  localparam logic [2:0] SEQ_IDX_RST = 3'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] SEQ_RESET_IDX = 3'h0;
  // Field positions
  localparam int FEAT_VSC_BIT = 3;
  localparam int STAT_DEN_BIT = 0;
  localparam int STAT_VRT_BIT = 3;
  localparam int STAT_FB_LO = 4;
  localparam int MISC_IOSEL_BIT = 0;
  localparam int MISC_APER_BIT = 1;
  localparam int MISC_PAGE_BIT = 5;
  localparam int MISC_HPOL_BIT = 6;
  localparam int MISC_VPOL_BIT = 7;
  localparam int MISC_RSVD_BIT = 4;
  localparam int SEQ_RSV1_BIT = 1;
  localparam int MISC_CLK_LO = 2;
  localparam int MISC_CLK_W = 2;
  localparam int SEQ_IDX_W = 3;
  localparam logic [1:0] CLK_SEL_LOW = 2'h0;
  localparam logic [1:0] CLK_SEL_HIGH = 2'h1;

  // Host I/O request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lvs_io_req_t;

  // Pipe timing status from a display pipe, legacy or assigned
  typedef struct packed {
    logic vretrace;
    logic blank;
    logic [7:0] pixel;
  } lvs_pipe_t;

  // Decoded misc output controls
  typedef struct packed {
    logic vsync_neg;
    logic hsync_neg;
    logic page_lower;
    logic [1:0] clk_sel;
    logic aper_en;
    logic io_colour;
  } lvs_misc_t;
endpackage

// ==== design/lvs_regs.sv ====
// Legacy display status, feature, misc output and sequencer index registers
`timescale 1ns/1ps
module lvs_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire lvs_pkg::lvs_io_req_t io_req,
  input wire lvs_pkg::lvs_pipe_t legacy_pipe,
  input wire lvs_pkg::lvs_pipe_t assigned_pipe,
  input wire logic legacy_disable,
  input wire logic native_mode,
  input wire logic odd_even_mode,
  input wire logic [1:0] plane_fb_sel,
  input wire logic port_vsync_neg,
  input wire logic port_hsync_neg,
  input wire logic [1:0] fixed_clk_sel,
  input wire logic aper_access,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output lvs_pkg::lvs_misc_t misc_ctrl,
  output logic vsync_neg_q,
  output logic hsync_neg_q,
  output logic page_lower_q,
  output logic [1:0] dot_clk_sel_q,
  output logic aper_grant_q,
  output logic retrace_irq_q
);
  import lvs_pkg::*;

  // Stored misc fields; reserved bit 4 has no storage
  logic vpol_q;
  logic hpol_q;
  logic page_q;
  logic [MISC_CLK_W-1:0] clk_code_q;
  logic aper_en_q;
  logic io_colour_q;
  // Other stored state
  logic feat_vsc_q;
  logic [SEQ_IDX_W-1:0] seq_idx_q;
  // Assembled bytes
  logic [7:0] misc_rd;
  logic [7:0] stat_d;
  logic [7:0] rdata_d;
  lvs_pipe_t src;
  // Port decode
  logic mono_hit;
  logic colr_hit;
  logic stat_hit;
  logic misc_wr_hit;
  logic misc_rd_hit;
  logic feat_rd_hit;
  logic idx_hit;
  logic dat_hit;
  logic misc_we;
  logic feat_we;
  logic idx_we;

  ////////////////////////////////////////////////////////////////////////////
  // Colour bit pair chosen by the plane enable select field
  function automatic logic [1:0] fb_pick(input logic [7:0] px, input logic [1:0] sel);
    unique case (sel)
      2'h0: fb_pick = {px[4], px[0]};
      2'h1: fb_pick = {px[5], px[1]};
      2'h2: fb_pick = {px[3], px[2]};
      2'h3: fb_pick = {px[7], px[6]};
    endcase
  endfunction

  // Exact port compare; a partial match would alias neighbour ports
  function automatic logic port_is(input logic [15:0] a, input logic [15:0] p);
    port_is = (a == p);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Base decode; both ranges claimed, so no mono adapter can coexist
  assign mono_hit = port_is(io_req.addr, PORT_STAT_MONO);
  assign colr_hit = port_is(io_req.addr, PORT_STAT_COLR);
  assign stat_hit = mono_hit | colr_hit;

  // Remaining ports need a full match
  assign misc_wr_hit = port_is(io_req.addr, PORT_MISC_WR);
  assign misc_rd_hit = port_is(io_req.addr, PORT_MISC_RD);
  assign feat_rd_hit = port_is(io_req.addr, PORT_FEAT_RD);
  assign idx_hit = port_is(io_req.addr, PORT_SEQ_IDX);
  assign dat_hit = port_is(io_req.addr, PORT_SEQ_DAT);

  // Write enables; status ports only reach the feature bit
  assign misc_we = io_req.wr & misc_wr_hit;
  assign feat_we = io_req.wr & stat_hit;
  assign idx_we = io_req.wr & idx_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Status source follows the pipe that owns legacy timing
  assign src = legacy_disable ? assigned_pipe : legacy_pipe;

  // Status byte assembly, unused positions forced low
  always_comb begin
    stat_d = ZERO_BYTE;
    stat_d[STAT_DEN_BIT] = src.blank;
    stat_d[STAT_VRT_BIT] = src.vretrace;
    stat_d[STAT_FB_LO +: 2] = fb_pick(src.pixel, plane_fb_sel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical sync polarity field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vpol_q <= MISC_RST[MISC_VPOL_BIT];
    end else if (misc_we) begin
      vpol_q <= io_req.wdata[MISC_VPOL_BIT];
    end
  end

  // Horizontal sync polarity field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hpol_q <= MISC_RST[MISC_HPOL_BIT];
    end else if (misc_we) begin
      hpol_q <= io_req.wdata[MISC_HPOL_BIT];
    end
  end

  // Page select field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_q <= MISC_RST[MISC_PAGE_BIT];
    end else if (misc_we) begin
      page_q <= io_req.wdata[MISC_PAGE_BIT];
    end
  end

  // Dot clock code, stored raw; decoded at the output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_code_q <= MISC_RST[MISC_CLK_LO +: MISC_CLK_W];
    end else if (misc_we) begin
      clk_code_q <= io_req.wdata[MISC_CLK_LO +: MISC_CLK_W];
    end
  end

  // Legacy aperture enable field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aper_en_q <= MISC_RST[MISC_APER_BIT];
    end else if (misc_we) begin
      aper_en_q <= io_req.wdata[MISC_APER_BIT];
    end
  end

  // I/O base select; stored only, since both ranges stay claimed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_colour_q <= MISC_RST[MISC_IOSEL_BIT];
    end else if (misc_we) begin
      io_colour_q <= io_req.wdata[MISC_IOSEL_BIT];
    end
  end

  // Misc read-back, reserved bit 4 reads zero
  always_comb begin
    misc_rd = ZERO_BYTE;
    misc_rd[MISC_VPOL_BIT] = vpol_q;
    misc_rd[MISC_HPOL_BIT] = hpol_q;
    misc_rd[MISC_PAGE_BIT] = page_q;
    misc_rd[MISC_CLK_LO +: MISC_CLK_W] = clk_code_q;
    misc_rd[MISC_APER_BIT] = aper_en_q;
    misc_rd[MISC_IOSEL_BIT] = io_colour_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature control, only the storage bit is kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feat_vsc_q <= FEAT_RST[FEAT_VSC_BIT];
    end else if (feat_we) begin
      feat_vsc_q <= io_req.wdata[FEAT_VSC_BIT];
    end
  end

  // Sequencer index; data port at index 00 stores nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_idx_q <= SEQ_IDX_RST;
    end else if (idx_we) begin
      seq_idx_q <= io_req.wdata[SEQ_IDX_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read select; unmapped and data port reads return zero
  always_comb begin
    rdata_d = ZERO_BYTE;
    if (stat_hit) begin
      rdata_d = stat_d;
    end else if (feat_rd_hit) begin
      rdata_d[FEAT_VSC_BIT] = feat_vsc_q;
    end else if (misc_rd_hit) begin
      rdata_d = misc_rd;
    end else if (idx_hit) begin
      rdata_d[SEQ_IDX_W-1:0] = seq_idx_q;
    end else if (dat_hit) begin
      rdata_d = ZERO_BYTE;
    end
  end

  // Answer strobe, one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_req.rd;
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= ZERO_BYTE;
    end else begin
      io_rdata <= io_req.rd ? rdata_d : ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Misc fields as one bundle, one cycle behind the register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_ctrl <= '0;
    end else begin
      misc_ctrl.vsync_neg <= vpol_q;
      misc_ctrl.hsync_neg <= hpol_q;
      misc_ctrl.page_lower <= page_q;
      misc_ctrl.clk_sel <= clk_code_q;
      misc_ctrl.aper_en <= aper_en_q;
      misc_ctrl.io_colour <= io_colour_q;
    end
  end

  // Port control wins outside native mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vsync_neg_q <= 1'b0;
    end else begin
      vsync_neg_q <= native_mode ? vpol_q : port_vsync_neg;
    end
  end

  // Same choice for the horizontal sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsync_neg_q <= 1'b0;
    end else begin
      hsync_neg_q <= native_mode ? hpol_q : port_hsync_neg;
    end
  end

  // Page bit only meaningful in odd/even map
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_lower_q <= 1'b0;
    end else begin
      page_lower_q <= odd_even_mode & page_q;
    end
  end

  // In native mode, reserved and unused codes fall back to the low clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dot_clk_sel_q <= CLK_SEL_LOW;
    end else if (!native_mode) begin
      dot_clk_sel_q <= fixed_clk_sel;
    end else if (clk_code_q == CLK_SEL_HIGH) begin
      dot_clk_sel_q <= CLK_SEL_HIGH;
    end else begin
      dot_clk_sel_q <= CLK_SEL_LOW;
    end
  end

  // Linear frame buffer never reaches this gate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aper_grant_q <= 1'b0;
    end else begin
      aper_grant_q <= aper_access & aper_en_q;
    end
  end

  // Retrace never interrupts; old enable bits are not decoded
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      retrace_irq_q <= 1'b0;
    end else begin
      retrace_irq_q <= 1'b0;
    end
  end
endmodule // lvs_regs

// ==== verif/lvs_regs_props.sv ====
// Checker for the legacy display register bank
`timescale 1ns/1ps
module lvs_regs_props
  import lvs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire lvs_pkg::lvs_io_req_t io_req,
  input wire lvs_pkg::lvs_pipe_t legacy_pipe,
  input wire lvs_pkg::lvs_pipe_t assigned_pipe,
  input wire logic legacy_disable,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic retrace_irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A read strobe at one port
  sequence s_rd(logic [15:0] a);
    io_req.rd && io_req.addr == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_IRQ: assert property (!retrace_irq_q) else $error("retrace irq raised");
  AST_RVALID: assert property (io_req.rd |=> io_rvalid) else $error("no read answer");
  AST_STAT_RSVD: assert property (s_rd(PORT_STAT_COLR) |=>
    (io_rdata & 8'hc6) == 8'h00) else $error("status reserved bits set");
  // Status is sampled at the strobe edge from the selected pipe
  AST_VRT: assert property (s_rd(PORT_STAT_MONO) |=> io_rdata[3] ==
    $past(legacy_disable ? assigned_pipe.vretrace : legacy_pipe.vretrace))
    else $error("retrace bit wrong");
  AST_DEN: assert property (s_rd(PORT_STAT_COLR) |=> io_rdata[0] ==
    $past(legacy_disable ? assigned_pipe.blank : legacy_pipe.blank)) else $error("blank bit wrong");
  AST_FEAT: assert property (s_rd(PORT_FEAT_RD) |=>
    (io_rdata & 8'hf7) == 8'h00) else $error("feature spare bits set");
  AST_IDX: assert property (s_rd(PORT_SEQ_IDX) |=>
    io_rdata[7:3] == 5'h00) else $error("index upper bits set");
  AST_SEQ: assert property (s_rd(PORT_SEQ_DAT) |=>
    io_rdata == 8'h00) else $error("sequencer data not zero");
endmodule // lvs_regs_props
bind lvs_regs lvs_regs_props u_props (.clk(clk), .rst_b(rst_b), .io_req(io_req),
  .legacy_pipe(legacy_pipe), .assigned_pipe(assigned_pipe), .legacy_disable(legacy_disable),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid), .retrace_irq_q(retrace_irq_q));

// ==== verif/lvs_host.sv ====
// Host model issuing byte-wide legacy port cycles
`timescale 1ns/1ps
module lvs_host
  import lvs_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  output lvs_pkg::lvs_io_req_t io_req
);
  initial io_req = '0;
  // One byte per call; callers order index before data
  task automatic xfer(input logic r, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    io_req = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk);
    // Released bus shows inverted values so stale data cannot pass
    #1 io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    // A missing or stray answer strobe spoils the data
    q = (io_rvalid == r) ? io_rdata : 'x;
    @(posedge clk);
    #1;
  endtask
endmodule // lvs_host

// ==== verif/lvs_regs_tb.sv ====
// Self-checking bench for the legacy display register bank
`timescale 1ns/1ps
module lvs_regs_tb;
  import lvs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  lvs_io_req_t io_req;
  lvs_pipe_t lp = '0;
  lvs_pipe_t ap = '0;
  logic dis = 1'b0, nat = 1'b0, oe = 1'b0, pvn = 1'b0, phn = 1'b0, acc = 1'b0;
  logic rv, vn, hn, pl, ag, irq;
  logic [1:0] fbs = 2'h0, fcs = 2'h0, dcs;
  logic [7:0] rdata, q;
  lvs_misc_t mc;
  int bad_count = 0, checked = 0;
  always #2.5 clk = ~clk;
  lvs_regs dut (.clk(clk), .rst_b(rst_b), .io_req(io_req), .legacy_pipe(lp), .assigned_pipe(ap),
    .legacy_disable(dis), .native_mode(nat), .odd_even_mode(oe), .plane_fb_sel(fbs),
    .port_vsync_neg(pvn), .port_hsync_neg(phn), .fixed_clk_sel(fcs), .aper_access(acc),
    .io_rdata(rdata), .io_rvalid(rv), .misc_ctrl(mc), .vsync_neg_q(vn), .hsync_neg_q(hn),
    .page_lower_q(pl), .dot_clk_sel_q(dcs), .aper_grant_q(ag), .retrace_irq_q(irq));
  lvs_host host (.clk(clk), .io_rdata(rdata), .io_rvalid(rv), .io_req(io_req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, q);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  // Defaults straight after reset
  task automatic t_reset();
    rd_chk("misc", PORT_MISC_RD, 8'h00);
    rd_chk("feat", PORT_FEAT_RD, 8'h00);
    rd_chk("index", PORT_SEQ_IDX, 8'h00);
    rd_chk("status", PORT_STAT_COLR, 8'h00);
  endtask
  // Misc fields reach outputs; port settings rule outside native mode
  task automatic t_misc();
    nat = 1'b1;
    oe = 1'b1;
    acc = 1'b1;
    wr(PORT_MISC_WR, 8'hff);
    rd_chk("misc", PORT_MISC_RD, 8'hef);
    chk("sync", {6'h00, vn, hn}, 8'h03);
    chk("ctl", {4'h0, pl, ag, dcs}, 8'h0c);
    chk("bundle", {1'b0, mc}, 8'h7f);
    wr(PORT_MISC_WR, 8'h04);
    chk("ctl", {4'h0, pl, ag, dcs}, 8'h01);
    chk("bundle", {1'b0, mc}, 8'h04);
    nat = 1'b0;
    pvn = 1'b1;
    fcs = 2'h2;
    repeat (2) @(posedge clk);
    #1;
    chk("port", {5'h00, vn, dcs}, 8'h06);
  endtask
  // Feature bit 3 is written at both status ports, read at its own
  task automatic t_feat();
    wr(PORT_STAT_COLR, 8'hff);
    rd_chk("feat", PORT_FEAT_RD, 8'h08);
    rd_chk("status", PORT_STAT_COLR, 8'h00);
    wr(PORT_STAT_MONO, 8'h00);
    rd_chk("feat", PORT_FEAT_RD, 8'h00);
  endtask
  // Every feedback selection, then the assigned pipe as source
  task automatic t_stat();
    logic [7:0] px [4] = '{8'h10, 8'h02, 8'h08, 8'h40};
    logic [7:0] ex [4] = '{8'h29, 8'h19, 8'h29, 8'h19};
    lp = '{vretrace: 1'b1, blank: 1'b1, pixel: 8'h00};
    for (int i = 0; i < 4; i++) begin
      fbs = i[1:0];
      lp.pixel = px[i];
      rd_chk("status", PORT_STAT_MONO, ex[i]);
    end
    dis = 1'b1;
    lp = '0;
    ap = '{vretrace: 1'b1, blank: 1'b1, pixel: 8'hc0};
    rd_chk("status", PORT_STAT_COLR, 8'h39);
  endtask
  // Index width, the zero register at index 0, an unmapped port
  task automatic t_seq();
    wr(PORT_SEQ_IDX, 8'hff);
    rd_chk("index", PORT_SEQ_IDX, 8'h07);
    wr(PORT_SEQ_IDX, 8'h00);
    wr(PORT_SEQ_DAT, 8'hff);
    rd_chk("seqdat", PORT_SEQ_DAT, 8'h00);
    rd_chk("unmapped", 16'h03c3, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_misc();
    t_feat();
    t_stat();
    t_seq();
    results();
  end
endmodule // lvs_regs_tb
